// *** rtl/fpdi_core.sv ***
// Command handler for deep power-down and identification reads
`default_nettype none

module fpdi_core #(
    parameter logic [7:0]  MFR_ID     = 8'h5c,                // Arbitrary value
    parameter logic [7:0]  SIG_ID     = 8'h17,                // Arbitrary value
    parameter logic [7:0]  DEV_ID     = 8'h17,                // Arbitrary value
    parameter logic [7:0]  MEM_TYPE   = 8'h40,                // Arbitrary value
    parameter logic [7:0]  CAPACITY   = 8'h18,                // Arbitrary value
    parameter logic [63:0] UNIQUE_ID  = 64'h0123_4567_89ab_cdef, // Arbitrary
    parameter logic [127:0] PARAM_HEAD = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          spi_clk,
    input  wire logic          spi_cs_n,
    input  wire logic [3:0]    sio_in,
    output var  logic [3:0]    sio_out,
    output var  logic [3:0]    sio_oe,
    input  wire logic          busy_in,
    output var  logic          status_busy,
    output logic               power_down,
    output logic               cmd_ready
);
    import fpdi_pkg::*;

    //**************************************************************************
    // Pin synchronisers
    //**************************************************************************
    logic       cs_s1_q, cs_s2_q, cs_s3_q;
    logic       clk_s1_q, clk_s2_q, clk_s3_q;
    logic [3:0] io_s1_q, io_s2_q;

    // Two flops on every pin, a third only for edge finding
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            cs_s3_q  <= 1'b1;
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            io_s1_q  <= 4'h0;
            io_s2_q  <= 4'h0;
        end else begin
            cs_s1_q  <= spi_cs_n;
            cs_s2_q  <= cs_s1_q;
            cs_s3_q  <= cs_s2_q;
            clk_s1_q <= spi_clk;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            io_s1_q  <= sio_in;
            io_s2_q  <= io_s1_q;
        end
    end

    logic cs_low, sclk_rise, sclk_fall, frame_end;

    // Edge events seen on the core clock
    assign cs_low    = !cs_s2_q;
    assign sclk_rise = cs_low && clk_s2_q && !clk_s3_q;
    assign sclk_fall = cs_low && !clk_s2_q && clk_s3_q;
    assign frame_end = cs_s2_q && !cs_s3_q;

    //**************************************************************************
    // Frame decode
    //**************************************************************************
    logic [6:0] cnt_q;
    logic [7:0] opc_sr_q, opc_q, opc_next, addr_lo_q;
    logic       cmd_ok_q, opc_take, accept;
    fpdi_pwr_e  pwr_q;

    // Rising link edges since chip select fell
    always_ff @(posedge core_clk) begin
        if (!rst_n || !cs_low) begin
            cnt_q <= 7'h00;
        end else if (sclk_rise && cnt_q != CNT_MAX) begin
            cnt_q <= cnt_q + 7'h01;
        end
    end

    // Opcode shift register on the single input line
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            opc_sr_q <= 8'h00;
        end else if (sclk_rise && cnt_q < CNT_OPC) begin
            opc_sr_q <= opc_next;
        end
    end

    assign opc_next = {opc_sr_q[6:0], io_s2_q[0]};
    assign opc_take = sclk_rise && cnt_q == CNT_OPC - 7'h01;

    // Which opcodes are honoured in the present state
    always_comb begin
        accept = 1'b0;
        if (opc_next == OPC_RELEASE) begin
            accept = !busy_in;
        end else if (pwr_q == FPDI_ACTIVE) begin
            case (opc_next)
                OPC_PWR_DOWN, OPC_MFR_ID, OPC_MFR_DUAL, OPC_MFR_QUAD,
                OPC_UNIQUE, OPC_STD_ID, OPC_PARAM: accept = 1'b1;
                default: accept = 1'b0;
            endcase
        end
    end

    // Opcode and its verdict, held for the frame
    always_ff @(posedge core_clk) begin
        if (!rst_n || !cs_low) begin
            opc_q    <= 8'h00;
            cmd_ok_q <= 1'b0;
        end else if (opc_take) begin
            opc_q    <= opc_next;
            cmd_ok_q <= accept;
        end
    end

    // Low address byte picks the first parameter byte
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            addr_lo_q <= 8'h00;
        end else if (sclk_rise && cnt_q >= ADDR_LO_BEG && cnt_q < LEAD_MFR) begin
            addr_lo_q <= {addr_lo_q[6:0], io_s2_q[0]};
        end
    end

    //**************************************************************************
    // Power state
    //**************************************************************************
    logic [TMR_W-1:0] tmr_q;
    logic             dp_req, rel_bare, rel_sig;

    assign dp_req   = frame_end && cmd_ok_q && opc_q == OPC_PWR_DOWN
                      && cnt_q == CNT_OPC && pwr_q == FPDI_ACTIVE;
    assign rel_bare = frame_end && cmd_ok_q && opc_q == OPC_RELEASE
                      && cnt_q == CNT_OPC && pwr_q[0];
    assign rel_sig  = frame_end && cmd_ok_q && opc_q == OPC_RELEASE
                      && cnt_q > CNT_OPC && pwr_q[0];

    // Entry and release timing
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pwr_q <= FPDI_ACTIVE;
            tmr_q <= '0;
        end else if (dp_req) begin
            pwr_q <= FPDI_ENTERING;
            tmr_q <= TMR_W'(TDP_CYC);
        end else if (rel_bare) begin
            pwr_q <= FPDI_WAKING;
            tmr_q <= TMR_W'(RES1_CYC);
        end else if (rel_sig) begin
            pwr_q <= FPDI_WAKING;
            tmr_q <= TMR_W'(RES2_CYC);
        end else if (tmr_q != '0) begin
            tmr_q <= tmr_q - TMR_W'(1);
            if (tmr_q == TMR_W'(1)) begin
                case (pwr_q)
                    FPDI_ENTERING: pwr_q <= FPDI_DOWN;
                    FPDI_WAKING:   pwr_q <= FPDI_ACTIVE;
                    default:       pwr_q <= pwr_q;
                endcase
            end
        end
    end

    assign power_down = pwr_q == FPDI_DOWN;
    assign cmd_ready  = pwr_q == FPDI_ACTIVE;

    // Busy flag mirrors the self-timed engine
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_busy <= 1'b0;
        end else begin
            status_busy <= busy_in;
        end
    end

    //**************************************************************************
    // Data out
    //**************************************************************************
    // Byte number idx of the answer to opc
    function automatic logic [7:0] data_byte(input logic [7:0] opc,
                                             input logic [7:0] idx,
                                             input logic [7:0] base);
        logic [7:0] pa;
        pa = base + idx;
        case (opc)
            OPC_RELEASE:  data_byte = SIG_ID;
            OPC_MFR_ID, OPC_MFR_DUAL, OPC_MFR_QUAD:
                data_byte = idx[0] ? DEV_ID : MFR_ID;
            OPC_UNIQUE:   data_byte = 8'(UNIQUE_ID >> {~idx[2:0], 3'h0});
            OPC_STD_ID: begin
                case (idx)
                    8'h00:   data_byte = MFR_ID;
                    8'h01:   data_byte = MEM_TYPE;
                    8'h02:   data_byte = CAPACITY;
                    default: data_byte = FILL_BYTE;
                endcase
            end
            OPC_PARAM: data_byte = (pa < 8'(PARAM_HEAD_N))
                                   ? 8'(PARAM_HEAD >> {~pa[3:0], 3'h0}) : FILL_BYTE;
            default: data_byte = FILL_BYTE;
        endcase
    endfunction : data_byte

    // Top bits of a byte placed on the lines in use
    function automatic logic [3:0] line_bits(input logic [7:0] v,
                                             input logic [3:0] w);
        case (w)
            4'h2:    line_bits = {2'h0, v[7:6]};
            4'h4:    line_bits = v[7:4];
            default: line_bits = {2'h0, v[7], 1'b0};
        endcase
    endfunction : line_bits

    logic [7:0] sr_q, byte_idx_q, cur;
    logic [3:0] bits_left_q, w;
    logic       data_phase, shift_ev, load;

    assign w          = width_of(opc_q);
    assign data_phase = cmd_ok_q && lead_of(opc_q) != 7'h00
                        && cnt_q >= lead_of(opc_q);
    assign shift_ev   = sclk_fall && data_phase;
    assign load       = bits_left_q == 4'h0;
    assign cur        = load ? data_byte(opc_q, byte_idx_q, addr_lo_q) : sr_q;

    // Output shifter, one step per falling link edge
    always_ff @(posedge core_clk) begin
        if (!rst_n || !cs_low) begin
            sr_q        <= 8'h00;
            bits_left_q <= 4'h0;
            byte_idx_q  <= 8'h00;
            sio_out     <= 4'h0;
            sio_oe      <= 4'h0;
        end else if (shift_ev) begin
            sr_q        <= 8'(cur << w);
            bits_left_q <= load ? 4'h8 - w : bits_left_q - w;
            byte_idx_q  <= load ? byte_idx_q + 8'h01 : byte_idx_q;
            sio_out     <= line_bits(cur, w);
            sio_oe      <= line_bits(8'hff, w);
        end
    end

    //**************************************************************************
    // Checks
    //**************************************************************************
    localparam int DP_MAX = TDP_CYC + 1;
    localparam int W1     = RES1_CYC;
    localparam int W2     = RES2_CYC;

    a_pd_entry_time: assert property (@(posedge core_clk) disable iff (!rst_n)
        dp_req |-> ##[1:DP_MAX] pwr_q == FPDI_DOWN)
        else $error("power-down not reached in time");

    a_pd_boundary_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        frame_end && opc_q == OPC_PWR_DOWN && cnt_q != CNT_OPC
        && pwr_q == FPDI_ACTIVE |=> pwr_q == FPDI_ACTIVE)
        else $error("power-down taken off a byte boundary");

    a_down_ignores: assert property (@(posedge core_clk) disable iff (!rst_n)
        opc_take && pwr_q != FPDI_ACTIVE && opc_next != OPC_RELEASE
        |=> !cmd_ok_q ##1 sio_oe == 4'h0)
        else $error("command honoured while powered down");

    a_reset_active: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$past(rst_n) |-> pwr_q == FPDI_ACTIVE && !power_down)
        else $error("not active after reset");

    a_release_time: assert property (@(posedge core_clk) disable iff (!rst_n)
        rel_bare |-> ##W1 pwr_q == FPDI_WAKING ##1 pwr_q == FPDI_ACTIVE)
        else $error("release time wrong");

    a_release_id_time: assert property (@(posedge core_clk) disable iff (!rst_n)
        rel_sig |-> ##W2 pwr_q == FPDI_WAKING ##1 pwr_q == FPDI_ACTIVE)
        else $error("release with signature time wrong");

    a_busy_ignores: assert property (@(posedge core_clk) disable iff (!rst_n)
        opc_take && busy_in && opc_next == OPC_RELEASE
        |=> !cmd_ok_q && $stable(pwr_q))
        else $error("release taken while busy");

    a_oe_frame: assert property (@(posedge core_clk) disable iff (!rst_n)
        !cs_low |=> sio_oe == 4'h0 && byte_idx_q == 8'h00)
        else $error("lines driven outside a frame");

    a_std_id_first: assert property (@(posedge core_clk) disable iff (!rst_n)
        shift_ev && load && opc_q == OPC_STD_ID && byte_idx_q == 8'h00
        |=> sio_out[1] == MFR_ID[7] && sio_oe == 4'h2)
        else $error("standard ID does not open with maker byte");

    a_dual_alternate: assert property (@(posedge core_clk) disable iff (!rst_n)
        shift_ev && load && opc_q == OPC_MFR_DUAL && byte_idx_q[0]
        |=> sio_out[1:0] == DEV_ID[7:6] && sio_oe == 4'h3)
        else $error("dual ID does not alternate");

    a_param_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        shift_ev && load && opc_q == OPC_PARAM && byte_idx_q == 8'h00 |-> cnt_q == LEAD_PARAM)
        else $error("parameter data not on clock 40");

    a_busy_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        busy_in ##1 !busy_in |=> !status_busy ##0 $past(status_busy))
        else $error("busy flag does not follow engine");

    // Signature byte on every load
    a_sig_repeat: assert property (@(posedge core_clk) disable iff (!rst_n)
        shift_ev && load && opc_q == OPC_RELEASE
        |=> sio_out[1] == SIG_ID[7] && sio_oe == 4'h2)
        else $error("signature byte not repeated");

    // Maker byte on even loads
    a_mfr_first: assert property (@(posedge core_clk) disable iff (!rst_n)
        shift_ev && load && opc_q == OPC_MFR_ID && !byte_idx_q[0]
        |=> sio_out[1] == MFR_ID[7])
        else $error("maker byte out of place");

    // Dual reads open with the maker byte
    a_dual_first: assert property (@(posedge core_clk) disable iff (!rst_n)
        shift_ev && load && opc_q == OPC_MFR_DUAL && !byte_idx_q[0]
        |=> sio_out[1:0] == MFR_ID[7:6] && sio_oe == 4'h3)
        else $error("dual maker byte wrong");

    // Quad reads drive all four lines
    a_quad_lines: assert property (@(posedge core_clk) disable iff (!rst_n)
        shift_ev && load && opc_q == OPC_MFR_QUAD && !byte_idx_q[0]
        |=> sio_out == MFR_ID[7:4] && sio_oe == 4'hf)
        else $error("quad maker nibble wrong");

    // Serial number opens with its top bit
    a_unique_first: assert property (@(posedge core_clk) disable iff (!rst_n)
        shift_ev && load && opc_q == OPC_UNIQUE && byte_idx_q == 8'h00
        |=> sio_out[1] == UNIQUE_ID[63])
        else $error("serial number order wrong");

    // Byte zero follows the top of the table
    a_param_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
        shift_ev && load && opc_q == OPC_PARAM && addr_lo_q + byte_idx_q == 8'h00
        |=> sio_out[1] == PARAM_HEAD[127])
        else $error("parameter byte zero wrong");

endmodule : fpdi_core

`default_nettype wire

// *** rtl/fpdi_pkg.sv ***
// Constants, types and helpers of the power-down and identification handler
//******************************************************************************
// What this block does
// - Opcode B9h alone, then chip select rising, requests deep power-down
// - Power-down is dropped unless chip select rises right after eight bits
// - Power-down state is reached within the entry time after chip select rises
// - While powered down only opcode ABh is recognised, all others ignored
// - After reset the device is always in normal operation
// - Bare ABh releases power-down, commands accepted after the release time
// - ABh plus three dummy bytes returns the signature byte, MSB first
// - Signature byte repeats while clocked, chip select high ends it
// - Signature read from power-down resumes after the release-with-ID time
// - ABh is ignored while busy, the running cycle is untouched
// - 90h plus zero address returns maker byte then device byte
// - 92h takes address two bits per clock, answers two bits per clock
// - 94h takes dummy clocks and address four bits per clock, answers four
// - Wide ID reads alternate maker and device bytes until chip select rises
// - 4Bh plus four dummy bytes returns the 64-bit serial number
// - 9Fh returns maker, memory type and capacity bytes, MSB first
// - 5Ah, address, eight dummies; data starts on falling edge of clock 40
// - Busy flag reads one during self-timed cycles, zero once ready
//******************************************************************************
`default_nettype none

package fpdi_pkg;

    //**************************************************************************
    // Timing
    //**************************************************************************
    localparam int CLK_NS   = 25;    // Core clock period
    localparam int TDP_NS   = 3000;  // Power-down entry time, longest
    localparam int RELEASE_TIME_NS = 3000;  // Release time, least
    localparam int RELEASE_WITH_ID_TIME_NS = 1800;  // Release-with-ID time, least
    localparam int TDP_CYC  = TDP_NS / CLK_NS - 3;  // Less the pin sync delay
    localparam int RES1_CYC = (RELEASE_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int RES2_CYC = (RELEASE_WITH_ID_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W    = 12;

    //**************************************************************************
    // Opcodes
    //**************************************************************************
    localparam logic [7:0] OPC_PWR_DOWN = 8'hb9;
    localparam logic [7:0] OPC_RELEASE  = 8'hab;
    localparam logic [7:0] OPC_MFR_ID   = 8'h90;
    localparam logic [7:0] OPC_MFR_DUAL = 8'h92;
    localparam logic [7:0] OPC_MFR_QUAD = 8'h94;
    localparam logic [7:0] OPC_UNIQUE   = 8'h4b;
    localparam logic [7:0] OPC_STD_ID   = 8'h9f;
    localparam logic [7:0] OPC_PARAM    = 8'h5a;

    //**************************************************************************
    // Clock counts of each frame, counted in rising link clock edges
    //**************************************************************************
    localparam logic [6:0] CNT_OPC      = 7'h08;  // Opcode complete
    localparam logic [6:0] CNT_MAX      = 7'h7f;  // Counter saturation
    localparam logic [6:0] LEAD_SIG     = 7'h20;  // Opcode plus three dummy bytes
    localparam logic [6:0] LEAD_MFR     = 7'h20;  // Opcode plus 24-bit address
    localparam logic [6:0] LEAD_DUAL    = 7'h18;  // 12 address and 4 mode clocks
    localparam logic [6:0] LEAD_QUAD    = 7'h14;  // 6 address, 2 mode, 4 dummy
    localparam logic [6:0] LEAD_UNIQUE  = 7'h28;  // Four dummy bytes
    localparam logic [6:0] LEAD_STD     = 7'h08;  // Data right after opcode
    localparam logic [6:0] LEAD_PARAM   = 7'h28;  // Address plus eight dummies
    localparam logic [6:0] ADDR_LO_BEG  = 7'h18;  // First clock of address low byte
    localparam logic [7:0] FILL_BYTE    = 8'hff;  // Past the end of a table
    localparam int         PARAM_HEAD_N = 16;     // Stored parameter bytes

    //**************************************************************************
    // Types
    //**************************************************************************
    typedef enum logic [1:0] {
        FPDI_ACTIVE   = 2'h0,
        FPDI_ENTERING = 2'h1,
        FPDI_DOWN     = 2'h3,
        FPDI_WAKING   = 2'h2
    } fpdi_pwr_e;

    //**************************************************************************
    // Helpers
    //**************************************************************************
    // Clocks before data leaves, zero for a command with no data
    function automatic logic [6:0] lead_of(input logic [7:0] opc);
        case (opc)
            OPC_RELEASE:  lead_of = LEAD_SIG;
            OPC_MFR_ID:   lead_of = LEAD_MFR;
            OPC_MFR_DUAL: lead_of = LEAD_DUAL;
            OPC_MFR_QUAD: lead_of = LEAD_QUAD;
            OPC_UNIQUE:   lead_of = LEAD_UNIQUE;
            OPC_STD_ID:   lead_of = LEAD_STD;
            OPC_PARAM:    lead_of = LEAD_PARAM;
            default:      lead_of = 7'h00;
        endcase
    endfunction : lead_of

    // Bits shifted per link clock
    function automatic logic [3:0] width_of(input logic [7:0] opc);
        case (opc)
            OPC_MFR_DUAL: width_of = 4'h2;
            OPC_MFR_QUAD: width_of = 4'h4;
            default:      width_of = 4'h1;
        endcase
    endfunction : width_of

endpackage : fpdi_pkg

`default_nettype wire

// *** testbench/fpdi_core_tb_top.sv ***
// Self-checking bench of the power-down and identification handler
`default_nettype none

module fpdi_core_tb_top import fpdi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0]   T_MFR  = 8'ha7;  // Arbitrary identity value
    localparam logic [7:0]   T_SIG  = 8'h3c;  // Arbitrary identity value
    localparam logic [7:0]   T_DEV  = 8'h52;  // Arbitrary identity value
    localparam logic [7:0]   T_TYPE = 8'h61;
    localparam logic [7:0]   T_CAP  = 8'h19;
    localparam logic [63:0]  T_UID  = 64'hf00d_1234_5678_9abc;  // Arbitrary value
    localparam logic [127:0] T_HEAD = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;
    logic       core_clk = 1'h0;
    logic       rst_n;
    logic       busy_in;
    wire        spi_clk;
    wire        spi_cs_n;
    wire  [3:0] sio_in;
    logic [3:0] sio_out;
    logic [3:0] sio_oe;
    logic       status_busy;
    logic       power_down;
    logic       cmd_ready;
    int         fails       = 0;
    int         comparisons = 0;

    always #12.5 core_clk = ~core_clk;

    fpdi_core #(.MFR_ID(T_MFR), .SIG_ID(T_SIG), .DEV_ID(T_DEV), .MEM_TYPE(T_TYPE),
                .CAPACITY(T_CAP), .UNIQUE_ID(T_UID), .PARAM_HEAD(T_HEAD)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .busy_in(busy_in),
        .status_busy(status_busy), .power_down(power_down), .cmd_ready(cmd_ready)
    );

    fpdi_host_model host (
        .core_clk(core_clk), .sio_out(sio_out), .sio_oe(sio_oe),
        .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .sio_in(sio_in)
    );

    // Compare one result, report a mismatch at once
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Read frame; data and drive enables checked on every read clock
    task automatic rd(input logic [7:0] opc, input int lead, input logic [31:0] ser,
                      input logic [3:0] msk, input int mlo, input int mhi,
                      input int nrd, input int w, input logic [63:0] exp);
        logic [63:0] rx;
        int          ok;
        host.frame(opc, lead, ser, msk, mlo, mhi, nrd, w, rx, ok);
        chk(rx, exp);
        chk(64'(ok), 64'(nrd));
    endtask : rd

    // Count core cycles until a status level shows, bounded
    task automatic wait_for(input bit rdy, input logic v, output int n);
        n = 0;
        while (((rdy ? cmd_ready : power_down) !== v) && (n < 400)) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 400) begin
            fails++;
            finish_test();
        end
    endtask : wait_for

    // Levels right after reset
    task automatic t_reset();
        chk({57'h0, power_down, cmd_ready, sio_oe, status_busy}, 64'h20);
    endtask : t_reset

    // Single-width identification reads
    task automatic t_id_single();
        rd(OPC_STD_ID, 8, 32'h0, 4'h1, 0, 0, 32, 1,
           {32'h0, T_MFR, T_TYPE, T_CAP, FILL_BYTE});
        rd(OPC_RELEASE, 32, 32'h0, 4'h1, 0, 0, 24, 1, {40'h0, {3{T_SIG}}});
        rd(OPC_MFR_ID, 32, 32'h0, 4'h1, 0, 0, 32, 1, {32'h0, {2{T_MFR, T_DEV}}});
        rd(OPC_UNIQUE, 40, 32'h0, 4'h1, 0, 0, 64, 1, T_UID);
    endtask : t_id_single

    // Dual and quad identification reads, alternating bytes
    task automatic t_id_wide();
        rd(OPC_MFR_DUAL, 24, 32'h0, 4'h3, 12, 14, 16, 2,
           {32'h0, {2{T_MFR, T_DEV}}});
        rd(OPC_MFR_QUAD, 20, 32'h0, 4'hf, 6, 7, 16, 4, {4{T_MFR, T_DEV}});
    endtask : t_id_wide

    // Parameter read starting two bytes below the wrap
    task automatic t_param();
        rd(OPC_PARAM, 40, {16'h0, 8'hfe, 8'h00}, 4'h1, 0, 0, 32, 1,
           {32'h0, FILL_BYTE, FILL_BYTE, T_HEAD[127:120], T_HEAD[119:112]});
    endtask : t_param

    // Misaligned entry, entry, refused read, bare release
    task automatic t_pdown();
        logic [63:0] rx;
        int          ok;
        int          n;
        host.frame(OPC_PWR_DOWN, 9, 32'h0, 4'h1, 0, 0, 0, 1, rx, ok);
        repeat (200) @(posedge core_clk);
        #1;
        chk(64'(power_down), 64'h0);
        host.frame(OPC_PWR_DOWN, 8, 32'h0, 4'h1, 0, 0, 0, 1, rx, ok);
        wait_for(1'h0, 1'h1, n);
        chk(64'(n + 4 <= TDP_NS / CLK_NS), 64'h1);
        host.frame(OPC_STD_ID, 8, 32'h0, 4'h1, 0, 0, 16, 1, rx, ok);
        chk(64'(ok), 64'h0);
        chk(64'(power_down), 64'h1);
        host.frame(OPC_RELEASE, 8, 32'h0, 4'h1, 0, 0, 0, 1, rx, ok);
        wait_for(1'h1, 1'h1, n);
        chk(64'((n + 4 >= RELEASE_TIME_NS / CLK_NS) && (n <= 130)), 64'h1);
        chk(64'(power_down), 64'h0);
    endtask : t_pdown

    // Release refused while busy, then signature read out of power-down
    task automatic t_busy_wake();
        logic [63:0] rx;
        int          ok;
        int          n;
        host.frame(OPC_PWR_DOWN, 8, 32'h0, 4'h1, 0, 0, 0, 1, rx, ok);
        wait_for(1'h0, 1'h1, n);
        busy_in = 1'h1;
        repeat (2) @(posedge core_clk);
        #1;
        chk(64'(status_busy), 64'h1);
        host.frame(OPC_RELEASE, 8, 32'h0, 4'h1, 0, 0, 0, 1, rx, ok);
        repeat (200) @(posedge core_clk);
        #1;
        chk(64'(power_down), 64'h1);
        busy_in = 1'h0;
        repeat (2) @(posedge core_clk);
        #1;
        chk(64'(status_busy), 64'h0);
        host.frame(OPC_RELEASE, 32, 32'h0, 4'h1, 0, 0, 8, 1, rx, ok);
        chk(rx, {56'h0, T_SIG});
        wait_for(1'h1, 1'h1, n);
        chk(64'((n + 4 >= RELEASE_WITH_ID_TIME_NS / CLK_NS) && (n <= 80)), 64'h1);
    endtask : t_busy_wake

    // Counts, verdict and end of run
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if ((fails == 0) && (comparisons > 0)) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // Reset for twelve cycles, then each scenario in turn
    initial begin
        rst_n = 1'h0;
        busy_in = 1'h0;
        repeat (12) @(posedge core_clk);
        #1;
        rst_n = 1'h1;
        t_reset();
        repeat (3) @(posedge core_clk);
        #1;
        t_id_single();
        t_id_wide();
        t_param();
        t_pdown();
        t_busy_wake();
        finish_test();
    end

endmodule : fpdi_core_tb_top

`default_nettype wire

// *** testbench/fpdi_host_model.sv ***
// Host link controller model: chip select, link clock and data lines
`default_nettype none

module fpdi_host_model (
    input  wire logic       core_clk,
    input  wire logic [3:0] sio_out,
    input  wire logic [3:0] sio_oe,
    output var  logic       spi_clk,
    output var  logic       spi_cs_n,
    output wire logic [3:0] sio_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] host_v  = 4'h0;
    logic [3:0] host_oe = 4'h0;
    logic       flip    = 1'h0;

    // Lines nobody drives toggle each cycle so a stale level never passes
    always @(posedge core_clk) flip <= ~flip;
    assign sio_in = (sio_oe & sio_out) | (~sio_oe & host_oe & host_v)
                  | (~sio_oe & ~host_oe & {2{flip, ~flip}});

    // Link idles low with chip select high
    initial begin
        spi_clk  = 1'h0;
        spi_cs_n = 1'h1;
    end

    // Half a link period; changes land just after a core clock edge
    task automatic half();
        repeat (4) @(posedge core_clk);
        #1;
    endtask : half

    // One frame: opcode and lead clocks, then nrd read clocks of w bits
    task automatic frame(input logic [7:0] opc, input int lead, input logic [31:0] ser,
                         input logic [3:0] msk, input int mlo, input int mhi,
                         input int nrd, input int w, output logic [63:0] rx,
                         output int oe_ok);
        logic [39:0] tx;
        logic        md;
        tx = {opc, ser};
        rx = 64'h0;
        oe_ok = 0;
        spi_cs_n = 1'h0;
        for (int i = 0; i < lead; i++) begin
            md = (i >= mlo + 8) && (i < mhi + 8);
            host_oe = (i < 8) ? 4'h1 : msk;
            host_v = md ? 4'hf : {3'h0, tx[39 - i]};
            half();
            spi_clk = 1'h1;
            half();
            spi_clk = 1'h0;
        end
        host_oe = 4'h0;
        for (int k = 0; k < nrd; k++) begin
            half();
            oe_ok += int'(sio_oe === ((w == 1) ? 4'h2 : (w == 2) ? 4'h3 : 4'hf));
            rx = (w == 1) ? {rx[62:0], sio_in[1]}
               : (w == 2) ? {rx[61:0], sio_in[1:0]} : {rx[59:0], sio_in};
            spi_clk = 1'h1;
            half();
            spi_clk = 1'h0;
        end
        half();
        spi_cs_n = 1'h1;
        half();
    endtask : frame

endmodule : fpdi_host_model

`default_nettype wire
